// *** rtl/wsn_map.vh ***
// register map, field positions, reset values and timing constants of the waveform/no-load bank
`ifndef WSN_MAP_VH
`define WSN_MAP_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define WSN_IDX_WAVE_CTRL   6'h0C
`define WSN_IDX_WAVE_SRC    6'h0D
`define WSN_IDX_NOLOAD      6'h0E
`define WSN_IDX_STATUS      6'h10

// ****************************************************************
// reset values
// ****************************************************************
`define WSN_RST_WAVE_CTRL   8'h00
`define WSN_RST_WAVE_SRC    8'h00
`define WSN_RST_NOLOAD      8'h00

// ****************************************************************
// fields of the waveform source and rate register
// ****************************************************************
`define WSN_SEL2_HI         7
`define WSN_SEL2_LO         5
`define WSN_SEL1_HI         4
`define WSN_SEL1_LO         2
`define WSN_RATE_HI         1
`define WSN_RATE_LO         0

// source codes
`define WSN_SRC_CURRENT     3'h0
`define WSN_SRC_VOLTAGE     3'h1
`define WSN_SRC_ACTIVE      3'h2
`define WSN_SRC_REACTIVE    3'h3
`define WSN_SRC_APPARENT    3'h4
`define WSN_SRC_RMS         3'h5

// wave sampling enable bit of the control register
`define WSN_WAVE_EN_BIT     0

// ****************************************************************
// fields of the no-load configuration register
// ****************************************************************
`define WSN_COMP_DIS_BIT    7
`define WSN_RMS_NL_BIT      6
`define WSN_APP_HI          5
`define WSN_APP_LO          4
`define WSN_REA_HI          3
`define WSN_REA_LO          2
`define WSN_ACT_HI          1
`define WSN_ACT_LO          0

// ****************************************************************
// no-load thresholds as fractions of full scale
// ****************************************************************
`define WSN_FULL_SCALE      32'h007FFFFF
`define WSN_TH_0300         ((`WSN_FULL_SCALE * 32'h1E) / 32'h186A0)
`define WSN_TH_0150         ((`WSN_FULL_SCALE * 32'h0F) / 32'h186A0)
`define WSN_TH_0075         ((`WSN_FULL_SCALE * 32'h4B) / 32'hF4240)
`define WSN_TH_0037         ((`WSN_FULL_SCALE * 32'h25) / 32'hF4240)

// ****************************************************************
// timing: base clock is core clock / 5, then /32 .. /256
// ****************************************************************
`define WSN_PRESCALE_LAST   3'h4
`define WSN_DIV_32_LAST     8'h1F
`define WSN_DIV_64_LAST     8'h3F
`define WSN_DIV_128_LAST    8'h7F
`define WSN_DIV_256_LAST    8'hFF

`endif

// *** rtl/wsn_rate_gen.v ***
// waveform sample tick generator: core clock / 5, then / 32, 64, 128 or 256
`timescale 1ns/100ps
`include "wsn_map.vh"

module wsn_rate_gen (
    // clock and reset
    input  wire       clk,
    input  wire       reset,
    // control
    input  wire       run,
    input  wire [1:0] rateSel,
    // tick out
    output reg        sampleTick_r
);

    reg  [2:0] preCnt_r;
    reg  [7:0] divCnt_r;
    wire       baseTick;
    reg  [7:0] divLast;

    assign baseTick = (preCnt_r == `WSN_PRESCALE_LAST);

    always @* begin
        case (rateSel)
            2'h0:    divLast = `WSN_DIV_32_LAST;
            2'h1:    divLast = `WSN_DIV_64_LAST;
            2'h2:    divLast = `WSN_DIV_128_LAST;
            default: divLast = `WSN_DIV_256_LAST;
        endcase
    end

    // counters restart while stopped so the first sample after enable is a full period away
    always @(posedge clk) begin
        if (reset || !run) begin
            preCnt_r     <= 3'h0;
            divCnt_r     <= 8'h00;
            sampleTick_r <= 1'b0;
        end else begin
            sampleTick_r <= 1'b0;
            if (baseTick) begin
                preCnt_r <= 3'h0;
                // a rate change takes effect at the next wrap or at once if already past
                if (divCnt_r >= divLast) begin
                    divCnt_r     <= 8'h00;
                    sampleTick_r <= 1'b1;
                end else begin
                    divCnt_r <= divCnt_r + 8'h01;
                end
            end else begin
                preCnt_r <= preCnt_r + 3'h1;
            end
        end
    end

endmodule

// *** rtl/wsn_config_top.v ***
// waveform source/rate and no-load configuration bank with APB access
// Summary of operation
// - second channel selector bits 7..5 routes current, voltage, products, rms filter
// - first channel selector bits 4..2, same codes, rms gives low 24 bits
// - rate bits 1..0: core clock/5 divided by 32, 64, 128 or 256
// - no-load register bit 7 set disables reactive gain compensation over frequency
// - bit 6 enables rms-current no-load detection at apparent threshold level
// - apparent field bits 5..4: off, 0.030%, 0.015%, 0.0075% of full scale
// - reactive field bits 3..2: off, 0.015%, 0.0075%, 0.0037% of full scale
// - active field bits 1..0: off, 0.015%, 0.0075%, 0.0037% of full scale
// - samples are produced only while the wave sampling enable bit is set
`timescale 1ns/100ps
`include "wsn_map.vh"

module wsn_config_top (
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_r,
    output reg         pready_r,
    output reg         pslverr_r,
    // waveform sources from the metering datapath
    input  wire [23:0] currentWave,
    input  wire [23:0] voltageWave,
    input  wire [23:0] activeProduct,
    input  wire [23:0] reactiveProduct,
    input  wire [23:0] apparentProduct,
    input  wire [31:0] rmsFilterOut,
    // magnitudes compared against no-load thresholds
    input  wire [23:0] activeMag,
    input  wire [23:0] reactiveMag,
    input  wire [23:0] apparentMag,
    input  wire [23:0] rmsCurrentMag,
    // waveform sample outputs
    output reg  [23:0] firstWave_r,
    output reg  [31:0] secondWave_r,
    output reg         sampleValid_r,
    // controls to the metering datapath
    output reg         reactiveCompEn_r,
    output reg         activeRun_r,
    output reg         reactiveRun_r,
    output reg         apparentRun_r,
    output reg         rmsRun_r
);

    // ****************************************************************
    // registers and decode
    // ****************************************************************
    reg  [7:0]  waveCtrl_r;
    reg  [7:0]  waveSrc_r;
    reg  [7:0]  noload_r;
    reg  [31:0] rdData_nxt;
    reg         rdErr_nxt;
    wire        access;
    wire        wrDone;
    wire        sampleTick;
    wire [31:0] firstPick;
    wire [2:0]  secondWaveSourceSel;
    wire [2:0]  firstWaveSourceSel;
    wire [1:0]  sampleRateSel;
    wire        waveSamplingEnable;
    wire        reactiveCompDisable;
    wire        currentRmsNoloadEn;
    wire [1:0]  apparentNoloadLevel;
    wire [1:0]  reactiveNoloadLevel;
    wire [1:0]  activeNoloadLevel;
    wire        activeBelow;
    wire        reactiveBelow;
    wire        apparentBelow;
    wire        rmsBelow;

    assign access = psel && penable;
    // a write lands only at the edge where the slave answers ready
    assign wrDone = access && pready_r && pwrite;

    // true when the byte address hits the given register index
    function hitIdx;
        input [7:0] addr;
        input [5:0] idx;
        begin
            hitIdx = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
        end
    endfunction

    assign secondWaveSourceSel = waveSrc_r[`WSN_SEL2_HI:`WSN_SEL2_LO];
    assign firstWaveSourceSel  = waveSrc_r[`WSN_SEL1_HI:`WSN_SEL1_LO];
    assign sampleRateSel       = waveSrc_r[`WSN_RATE_HI:`WSN_RATE_LO];
    assign waveSamplingEnable  = waveCtrl_r[`WSN_WAVE_EN_BIT];
    assign reactiveCompDisable = noload_r[`WSN_COMP_DIS_BIT];
    assign currentRmsNoloadEn  = noload_r[`WSN_RMS_NL_BIT];
    assign apparentNoloadLevel = noload_r[`WSN_APP_HI:`WSN_APP_LO];
    assign reactiveNoloadLevel = noload_r[`WSN_REA_HI:`WSN_REA_LO];
    assign activeNoloadLevel   = noload_r[`WSN_ACT_HI:`WSN_ACT_LO];

    // ****************************************************************
    // register writes
    // ****************************************************************
    always @(posedge clk) begin
        if (reset) begin
            waveCtrl_r <= `WSN_RST_WAVE_CTRL;
            waveSrc_r  <= `WSN_RST_WAVE_SRC;
            noload_r   <= `WSN_RST_NOLOAD;
        end else if (wrDone) begin
            if (hitIdx(paddr, `WSN_IDX_WAVE_CTRL)) begin
                waveCtrl_r <= {7'h00, pwdata[`WSN_WAVE_EN_BIT]};
            end
            if (hitIdx(paddr, `WSN_IDX_WAVE_SRC)) begin
                waveSrc_r <= pwdata[7:0];
            end
            if (hitIdx(paddr, `WSN_IDX_NOLOAD)) begin
                noload_r <= pwdata[7:0];
            end
        end
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    always @* begin
        rdData_nxt = 32'h00000000;
        rdErr_nxt  = 1'b0;
        if (hitIdx(paddr, `WSN_IDX_WAVE_CTRL)) begin
            rdData_nxt = {24'h000000, waveCtrl_r};
        end else if (hitIdx(paddr, `WSN_IDX_WAVE_SRC)) begin
            rdData_nxt = {24'h000000, waveSrc_r};
        end else if (hitIdx(paddr, `WSN_IDX_NOLOAD)) begin
            rdData_nxt = {24'h000000, noload_r};
        end else if (hitIdx(paddr, `WSN_IDX_STATUS)) begin
            // status is read-only; writes to it are accepted and dropped
            rdData_nxt = {27'h0000000, waveSamplingEnable, rmsBelow,
                          apparentBelow, reactiveBelow, activeBelow};
        end else begin
            rdErr_nxt = 1'b1;
        end
    end

    // one wait state: ready comes on the second access cycle
    always @(posedge clk) begin
        if (reset) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else if (access && !pready_r) begin
            pready_r  <= 1'b1;
            pslverr_r <= rdErr_nxt;
            prdata_r  <= pwrite ? 32'h00000000 : rdData_nxt;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end
    end

    // ****************************************************************
    // waveform sampling
    // ****************************************************************
    // reserved codes give zero rather than a stale source
    function [31:0] pickSource;
        input [2:0] sel;
        begin
            case (sel)
                `WSN_SRC_CURRENT:  pickSource = {{8{currentWave[23]}}, currentWave};
                `WSN_SRC_VOLTAGE:  pickSource = {{8{voltageWave[23]}}, voltageWave};
                `WSN_SRC_ACTIVE:   pickSource = {{8{activeProduct[23]}}, activeProduct};
                `WSN_SRC_REACTIVE: pickSource = {{8{reactiveProduct[23]}}, reactiveProduct};
                `WSN_SRC_APPARENT: pickSource = {{8{apparentProduct[23]}}, apparentProduct};
                `WSN_SRC_RMS:      pickSource = rmsFilterOut;
                default:           pickSource = 32'h00000000;
            endcase
        end
    endfunction

    // first channel keeps only the low 24 bits of whatever source is picked
    assign firstPick = pickSource(firstWaveSourceSel);

    wsn_rate_gen uRate (
        .clk          (clk),
        .reset        (reset),
        .run          (waveSamplingEnable),
        .rateSel      (sampleRateSel),
        .sampleTick_r (sampleTick)
    );

    always @(posedge clk) begin
        if (reset) begin
            firstWave_r   <= 24'h000000;
            secondWave_r  <= 32'h00000000;
            sampleValid_r <= 1'b0;
        end else begin
            sampleValid_r <= sampleTick && waveSamplingEnable;
            if (sampleTick && waveSamplingEnable) begin
                secondWave_r <= pickSource(secondWaveSourceSel);
                firstWave_r  <= firstPick[23:0];
            end
        end
    end

    // ****************************************************************
    // no-load detection
    // ****************************************************************
    // threshold for a level code; fine selects the reactive/active table
    function [23:0] noloadThreshold;
        input [1:0] level;
        input       fine;
        reg   [31:0] th;
        begin
            th = 32'h00000000;
            case (level)
                2'h1:    th = fine ? `WSN_TH_0150 : `WSN_TH_0300;
                2'h2:    th = fine ? `WSN_TH_0075 : `WSN_TH_0150;
                2'h3:    th = fine ? `WSN_TH_0037 : `WSN_TH_0075;
                default: th = 32'h00000000;
            endcase
            noloadThreshold = th[23:0];
        end
    endfunction

    assign apparentBelow = (apparentNoloadLevel != 2'h0) &&
                           (apparentMag < noloadThreshold(apparentNoloadLevel, 1'b0));
    assign reactiveBelow = (reactiveNoloadLevel != 2'h0) &&
                           (reactiveMag < noloadThreshold(reactiveNoloadLevel, 1'b1));
    assign activeBelow   = (activeNoloadLevel != 2'h0) &&
                           (activeMag < noloadThreshold(activeNoloadLevel, 1'b1));
    assign rmsBelow      = currentRmsNoloadEn && (apparentNoloadLevel != 2'h0) &&
                           (rmsCurrentMag < noloadThreshold(apparentNoloadLevel, 1'b0));

    always @(posedge clk) begin
        if (reset) begin
            reactiveCompEn_r <= 1'b1;
            activeRun_r      <= 1'b1;
            reactiveRun_r    <= 1'b1;
            apparentRun_r    <= 1'b1;
            rmsRun_r         <= 1'b1;
        end else begin
            reactiveCompEn_r <= !reactiveCompDisable;
            activeRun_r      <= !activeBelow;
            reactiveRun_r    <= !reactiveBelow;
            apparentRun_r    <= !apparentBelow;
            rmsRun_r         <= !rmsBelow;
        end
    end

endmodule

// *** test/wsn_config_properties.sv ***
// assertion checker for the waveform/no-load configuration bank
`timescale 1ns/100ps
`include "wsn_map.vh"
module wsn_config_properties (
    // clock and reset
    input wire        clk,
    input wire        reset,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire        pready_r,
    input wire        pslverr_r,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    // magnitudes
    input wire [23:0] activeMag,
    input wire [23:0] reactiveMag,
    input wire [23:0] apparentMag,
    input wire [23:0] rmsCurrentMag,
    // outputs watched
    input wire        sampleValid_r,
    input wire        reactiveCompEn_r,
    input wire        activeRun_r,
    input wire        reactiveRun_r,
    input wire        apparentRun_r,
    input wire        rmsRun_r
);
    localparam [7:0] A_CTL = {`WSN_IDX_WAVE_CTRL, 2'b00};
    localparam [7:0] A_SRC = {`WSN_IDX_WAVE_SRC, 2'b00};
    localparam [7:0] A_NL  = {`WSN_IDX_NOLOAD, 2'b00};
    localparam [7:0] A_ST  = {`WSN_IDX_STATUS, 2'b00};
    reg  [7:0]  nlCfg_r, srcCfg_r;
    reg         enCfg_r, clean_r;
    reg  [11:0] gap_r;
    wire        apbWr  = psel && penable && pready_r && pwrite;
    wire        mapped = paddr == A_CTL || paddr == A_SRC || paddr == A_NL || paddr == A_ST;
    // ****************************************************************
    // shadow of the written configuration
    // ****************************************************************
    function ok(input [23:0] m, input [1:0] lv, input app);
        reg [23:0] th;
        case (lv)
            2'h1: th = app ? 24'h0009D4 : 24'h0004EA;
            2'h2: th = app ? 24'h0004EA : 24'h000275;
            default: th = app ? 24'h000275 : 24'h000136;
        endcase
        ok = lv == 2'h0 || m >= th;
    endfunction
    wire okA = ok(activeMag, nlCfg_r[1:0], 1'b0);
    wire okR = ok(reactiveMag, nlCfg_r[3:2], 1'b0);
    wire okV = ok(apparentMag, nlCfg_r[5:4], 1'b1);
    wire okI = !nlCfg_r[6] || ok(rmsCurrentMag, nlCfg_r[5:4], 1'b1);
    // a gap only counts once no config write has disturbed the divider
    always @(posedge clk) begin
        if (reset) begin
            nlCfg_r <= 8'h00;
            srcCfg_r <= 8'h00;
            enCfg_r <= 1'b0;
            clean_r <= 1'b0;
            gap_r <= 12'h000;
        end else begin
            if (apbWr && paddr == A_NL) nlCfg_r <= pwdata[7:0];
            if (apbWr && paddr == A_SRC) srcCfg_r <= pwdata[7:0];
            if (apbWr && paddr == A_CTL) enCfg_r <= pwdata[0];
            if (apbWr && (paddr == A_CTL || paddr == A_SRC)) clean_r <= 1'b0;
            else if (sampleValid_r) clean_r <= 1'b1;
            gap_r <= sampleValid_r ? 12'h001 : gap_r + 12'h001;
        end
    end
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_ack; psel && penable && !pready_r |=> pready_r ##1 !pready_r; endproperty
    property p_err; pready_r |-> pslverr_r == !mapped; endproperty
    property p_comp; apbWr && paddr == A_NL |-> ##2 reactiveCompEn_r == !$past(pwdata[7], 2);
    endproperty
    property p_act; !$past(reset) |-> activeRun_r == $past(okA); endproperty
    property p_rea; !$past(reset) |-> reactiveRun_r == $past(okR); endproperty
    property p_app; !$past(reset) |-> apparentRun_r == $past(okV); endproperty
    property p_rms; !$past(reset) |-> rmsRun_r == $past(okI); endproperty
    property p_idle; !enCfg_r && !$past(enCfg_r) && !$past(enCfg_r, 2) |-> !sampleValid_r;
    endproperty
    property p_rate; sampleValid_r && clean_r |-> gap_r == (12'h0A0 << srcCfg_r[1:0]); endproperty
    a_ack: assert property (p_ack) else $error("apb ready not one pulse after access");
    a_err: assert property (p_err) else $error("slave error wrong for address");
    a_comp: assert property (p_comp) else $error("compensation enable wrong");
    a_act: assert property (p_act) else $error("active run flag wrong");
    a_rea: assert property (p_rea) else $error("reactive run flag wrong");
    a_app: assert property (p_app) else $error("apparent run flag wrong");
    a_rms: assert property (p_rms) else $error("rms run flag wrong");
    a_idle: assert property (p_idle) else $error("sample while sampling disabled");
    a_rate: assert property (p_rate) else $error("sample interval wrong");
    c_rate: cover property (sampleValid_r && clean_r);
    c_below: cover property (!activeRun_r && !rmsRun_r);
    c_err: cover property (pready_r && pslverr_r);
endmodule

bind wsn_config_top wsn_config_properties wsn_config_properties_i (.*);

// *** test/tb_wsn_config_top.sv ***
// self-checking bench for the waveform/no-load configuration bank
`timescale 1ns/100ps
`include "wsn_map.vh"
module tb_wsn_config_top;
    reg         clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0, rmsFilterOut = 32'h0;
    reg  [23:0] currentWave = 0, voltageWave = 0, activeProduct = 0;
    reg  [23:0] reactiveProduct = 0, apparentProduct = 0;
    reg  [23:0] activeMag = 0, reactiveMag = 0, apparentMag = 0, rmsCurrentMag = 0;
    wire [31:0] prdata_r, secondWave_r;
    wire [23:0] firstWave_r;
    wire        pready_r, pslverr_r, sampleValid_r, reactiveCompEn_r;
    wire        activeRun_r, reactiveRun_r, apparentRun_r, rmsRun_r;
    localparam [7:0] A_CTL = {`WSN_IDX_WAVE_CTRL, 2'b00};
    localparam [7:0] A_SRC = {`WSN_IDX_WAVE_SRC, 2'b00};
    localparam [7:0] A_NL  = {`WSN_IDX_NOLOAD, 2'b00};
    localparam [7:0] A_ST  = {`WSN_IDX_STATUS, 2'b00};
    int n_fail = 0, n_tests = 0, mNl = 0, mEn = 0, lv = 0, n, r, s1, s2;
    int thP[4] = '{24'h0, 24'h4EA, 24'h275, 24'h136};
    int thS[4] = '{24'h0, 24'h9D4, 24'h4EA, 24'h275};
    logic [31:0] q;
    logic        e;
    wsn_config_top wsn_config_top_i (.*);
    always #20 clk = ~clk;
    // ****************************************************************
    // model and helpers
    // ****************************************************************
    function bit okm(int m, int l, bit app);
        okm = l == 0 || m >= (app ? thS[l] : thP[l]);
    endfunction
    function int stat();
        stat = !okm(activeMag, lv, 0) + 2 * !okm(reactiveMag, lv, 0)
            + 4 * !okm(apparentMag, lv, 1) + 8 * (mNl[6] && !okm(rmsCurrentMag, lv, 1))
            + 16 * mEn;
    endfunction
    function int pick(int th, int j);
        pick = j < 4 ? (th == 0 ? 0 : th - 1) : j < 8 ? th : $urandom % 4096;
    endfunction
    function [31:0] wexp(int s);
        case (s)
            0: wexp = {{8{currentWave[23]}}, currentWave};
            1: wexp = {{8{voltageWave[23]}}, voltageWave};
            2: wexp = {{8{activeProduct[23]}}, activeProduct};
            3: wexp = {{8{reactiveProduct[23]}}, reactiveProduct};
            4: wexp = {{8{apparentProduct[23]}}, apparentProduct};
            5: wexp = rmsFilterOut;
            default: wexp = 32'h0;
        endcase
    endfunction
    task stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // request held from setup until pready is sampled high
    task apb(input w, input [7:0] a, input [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready_r !== 1'b1 && k < 20);
        if (pready_r !== 1'b1) begin
            n_fail++;
            stop_test();
        end
        q = prdata_r;
        e = pslverr_r;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input string nm, input [7:0] a, input [31:0] x, input ex);
        apb(1'b0, a, 32'h0);
        chk(nm, q, x);
        chk("slave error", e, ex);
    endtask
    task waitS(output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (sampleValid_r !== 1'b1 && c < 3000);
        if (c >= 3000) begin
            n_fail++;
            stop_test();
        end
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        void'($urandom(95));
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd("wave ctrl", A_CTL, 0, 0);
        rd("source rate", A_SRC, 0, 0);
        rd("noload cfg", A_NL, 0, 0);
        rd("status", A_ST, 0, 0);
        chk("comp enable", reactiveCompEn_r, 1);
        rd("unmapped", 8'h3C, 0, 1);
        rd("misaligned", A_SRC + 8'h01, 0, 1);
        apb(1'b1, 8'h3C, 32'hFF);
        chk("unmapped write error", e, 1);
        apb(1'b1, A_ST, 32'hFF);
        chk("status write error", e, 0);
        for (int j = 0; j < 12; j++) begin
            lv = j % 4;
            mNl = ($urandom % 4) * 64 + lv * 21;
            activeMag <= pick(thP[lv], j);
            reactiveMag <= pick(thP[lv], j);
            apparentMag <= pick(thS[lv], j);
            rmsCurrentMag <= pick(thS[lv], j);
            apb(1'b1, A_NL, mNl);
            repeat (2) @(posedge clk);
            chk("active run", activeRun_r, okm(activeMag, lv, 0));
            chk("reactive run", reactiveRun_r, okm(reactiveMag, lv, 0));
            chk("apparent run", apparentRun_r, okm(apparentMag, lv, 1));
            chk("rms run", rmsRun_r, !mNl[6] || okm(rmsCurrentMag, lv, 1));
            chk("comp enable", reactiveCompEn_r, !mNl[7]);
            rd("noload cfg", A_NL, mNl, 0);
            rd("status", A_ST, stat(), 0);
        end
        apb(1'b1, A_CTL, 32'hFF);
        mEn = 1;
        rd("wave ctrl", A_CTL, 1, 0);
        for (int i = 0; i < 8; i++) begin
            r = i % 4;
            s1 = i;
            s2 = (i + 3) % 8;
            currentWave <= 24'($urandom);
            voltageWave <= 24'($urandom);
            activeProduct <= 24'($urandom);
            reactiveProduct <= 24'($urandom);
            apparentProduct <= 24'($urandom);
            rmsFilterOut <= $urandom;
            apb(1'b1, A_SRC, s2 * 32 + s1 * 4 + r);
            waitS(n);
            waitS(n);
            chk("interval", n, 160 << r);
            chk("first wave", firstWave_r, wexp(s1) & 32'h00FFFFFF);
            chk("second wave", secondWave_r, wexp(s2));
            rd("source rate", A_SRC, s2 * 32 + s1 * 4 + r, 0);
        end
        apb(1'b1, A_CTL, 32'hFE);
        mEn = 0;
        rd("status", A_ST, stat(), 0);
        n = 0;
        repeat (1400) begin
            @(posedge clk);
            if (sampleValid_r === 1'b1) n++;
        end
        chk("idle samples", n, 0);
        stop_test();
    end
endmodule
